// ---- logic/program_space_window.sv ----
// program space data window: maps upper data space onto a program memory page
// Functional notes
// - a data read goes to program memory only when address bit 15 and control bit 2 are set.
// - an 8-bit page register picks one of 256 program pages of 32K words each.
// - the program address is the page register on top of the low 15 effective address bits.
// - the low 15 data address bits map onto the low 15 program address bits, one word per address.
// - every data address from 0x8000 up is an image of program memory while the window is on.
// - only the low 16 bits of the 24-bit program word come back as read data.
// - window fetches wait while a table read or write is in progress.
// - outside a repeat loop a move or double move through the window costs one added cycle.
// - outside a repeat loop any other window instruction costs two added cycles.
// - in a repeat loop the first, last, interrupt-exit and resume iterations cost two added cycles.
// - other repeat iterations run in a single cycle with no added cycles.
`timescale 1ns/10ps
`include "window_regs.svh"
module program_space_window (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // register writes from the core
   input wire logic CTRL_WR,
   input wire logic [15:0] CTRL_WDATA,
   input wire logic PAGE_WR,
   input wire logic [7:0] PAGE_WDATA,
   output logic [15:0] CTRL_RDATA,
   output logic [7:0] PAGE_RDATA,
   // data read request from the core
   input wire logic REQ_VALID,
   input wire window_pkg::access_req_t REQ_INFO,
   input wire logic TABLE_BUSY,
   output logic STALL,
   output logic RD_VALID,
   output logic [15:0] RD_DATA,
   // ordinary data memory
   output logic DM_REQ,
   output logic [15:0] DM_ADDR,
   // program memory read port
   output logic PM_REQ,
   output logic [22:0] PM_ADDR,
   input wire logic PM_VALID,
   input wire logic [23:0] PM_RDATA
);
   logic rst_sync1_q;
   logic rst_sync2_q;
   logic rst_n;
   logic [15:0] core_control_reg_q;
   logic [7:0] window_page_reg_q;
   window_pkg::win_state_t state_q;
   logic hit;
   logic [1:0] extra_d;
   logic [1:0] extra_q;
   logic [22:0] addr_d;
   logic issue;
   logic cnt_busy;
   logic data_got_q;
   logic [15:0] data_q;
   logic finish;

   // reset release is synchronised; assertion stays asynchronous
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         rst_sync1_q <= 1'b0;
         rst_sync2_q <= 1'b0;
      end
      else
      begin
         rst_sync1_q <= 1'b1;
         rst_sync2_q <= rst_sync1_q;
      end
   end
   assign rst_n = rst_sync2_q;

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         core_control_reg_q <= `WIN_CTRL_RESET;
      else if (CTRL_WR)
         core_control_reg_q <= CTRL_WDATA;
   end

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         window_page_reg_q <= `WIN_PAGE_RESET;
      else if (PAGE_WR)
         window_page_reg_q <= PAGE_WDATA;
   end

   assign CTRL_RDATA = core_control_reg_q;
   assign PAGE_RDATA = window_page_reg_q;

   // window hit; the page is sampled at acceptance, so a page write lands on the next access
   assign hit = REQ_INFO.effective_address[`WIN_EA_TOP_BIT]
      & core_control_reg_q[`WIN_ENABLE_BIT];
   assign addr_d = {window_page_reg_q,
      REQ_INFO.effective_address[`WIN_EA_LOW_MSB:0]};

   // added cycles for this access
   always_comb
   begin
      extra_d = `WIN_EXTRA_NONE;
      if (!REQ_INFO.in_repeat)
      begin
         if (REQ_INFO.instr_class == window_pkg::INSTR_OTHER)
            extra_d = `WIN_EXTRA_OTHER;
         else
            extra_d = `WIN_EXTRA_MOVE;
      end
      else if (REQ_INFO.repeat_first | REQ_INFO.repeat_last
         | REQ_INFO.irq_exit | REQ_INFO.irq_resume)
         extra_d = `WIN_EXTRA_OTHER;
      else
         extra_d = `WIN_EXTRA_NONE;
   end

   // a fetch goes out from idle or once a held access sees the table unit free
   assign issue = ((state_q == window_pkg::ST_IDLE) & REQ_VALID & hit & ~TABLE_BUSY)
      | ((state_q == window_pkg::ST_HOLD) & ~TABLE_BUSY);

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         extra_q <= `WIN_EXTRA_NONE;
      else if ((state_q == window_pkg::ST_IDLE) & REQ_VALID & hit)
         extra_q <= extra_d;
   end

   extra_cycle_counter #(
      .WIDTH(`WIN_EXTRA_WIDTH)
   ) u_extra (
      .clk(CLK),
      .rst_n(rst_n),
      .load(issue),
      .load_val((state_q == window_pkg::ST_IDLE) ? extra_d : extra_q),
      .busy(cnt_busy)
   );

   assign finish = (state_q == window_pkg::ST_FETCH) & ~cnt_busy
      & (data_got_q | PM_VALID);

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         state_q <= window_pkg::ST_IDLE;
      else
      begin
         unique case (state_q)
            window_pkg::ST_IDLE:
            begin
               if (REQ_VALID & hit)
               begin
                  if (TABLE_BUSY)
                     state_q <= window_pkg::ST_HOLD;
                  else
                     state_q <= window_pkg::ST_FETCH;
               end
            end
            window_pkg::ST_HOLD:
            begin
               if (!TABLE_BUSY)
                  state_q <= window_pkg::ST_FETCH;
            end
            window_pkg::ST_FETCH:
            begin
               if (finish)
                  state_q <= window_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         PM_ADDR <= '0;
      else if ((state_q == window_pkg::ST_IDLE) & REQ_VALID & hit)
         PM_ADDR <= addr_d;
   end

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         PM_REQ <= 1'b0;
      else
         PM_REQ <= issue;
   end

   // program data may arrive before the added cycles have run out
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         data_got_q <= 1'b0;
         data_q <= `WIN_RESP_EMPTY;
      end
      else if (finish | issue)
         data_got_q <= 1'b0;
      else if ((state_q == window_pkg::ST_FETCH) & PM_VALID)
      begin
         data_got_q <= 1'b1;
         data_q <= PM_RDATA[`WIN_DATA_MSB:0];
      end
   end

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         RD_VALID <= 1'b0;
         RD_DATA <= `WIN_RESP_EMPTY;
      end
      else
      begin
         RD_VALID <= finish;
         if (finish)
            RD_DATA <= data_got_q ? data_q : PM_RDATA[`WIN_DATA_MSB:0];
      end
   end

   // misses go straight to data memory in the same cycle pattern as a plain read
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         DM_REQ <= 1'b0;
         DM_ADDR <= '0;
      end
      else
      begin
         DM_REQ <= (state_q == window_pkg::ST_IDLE) & REQ_VALID & ~hit;
         if ((state_q == window_pkg::ST_IDLE) & REQ_VALID & ~hit)
            DM_ADDR <= REQ_INFO.effective_address;
      end
   end

   assign STALL = (state_q != window_pkg::ST_IDLE) & ~finish;
endmodule : program_space_window

// ---- logic/window_regs.svh ----
// constants for the program space data window
`ifndef WINDOW_REGS_SVH
`define WINDOW_REGS_SVH
`define WIN_ENABLE_BIT 2
`define WIN_EA_TOP_BIT 15
`define WIN_EA_LOW_MSB 14
`define WIN_DATA_MSB 15
`define WIN_CTRL_RESET 16'h0000
`define WIN_PAGE_RESET 8'h00
`define WIN_EXTRA_NONE 2'h0
`define WIN_EXTRA_MOVE 2'h1
`define WIN_EXTRA_OTHER 2'h2
`define WIN_EXTRA_WIDTH 2
`define WIN_RESP_EMPTY 16'h0000
`endif

// ---- logic/window_pkg.sv ----
// types for the program space data window
package window_pkg;
   typedef enum logic [1:0] {INSTR_MOVE, INSTR_DOUBLE_MOVE, INSTR_OTHER} instr_class_t;
   typedef struct packed {
      logic [15:0] effective_address;
      instr_class_t instr_class;
      logic in_repeat;
      logic repeat_first;
      logic repeat_last;
      logic irq_exit;
      logic irq_resume;
   } access_req_t;
   typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_FETCH} win_state_t;
endpackage : window_pkg

// ---- logic/extra_cycle_counter.sv ----
// down counter that holds the core for a given number of added cycles
`timescale 1ns/10ps
module extra_cycle_counter #(
   parameter int WIDTH = 2
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // load
   input wire logic load,
   input wire logic [WIDTH-1:0] load_val,
   // status
   output logic busy
);
   logic [WIDTH-1:0] cnt_q;

   // refused at elaboration: a narrower counter cannot hold the two added cycles
   if (WIDTH < 2)
   begin : g_width_check
      $error("extra_cycle_counter: WIDTH must hold a count of two");
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_q <= '0;
      else if (load)
         cnt_q <= load_val;
      else if (cnt_q != '0)
         cnt_q <= cnt_q - WIDTH'(1);
   end

   assign busy = (cnt_q != '0);
endmodule : extra_cycle_counter

// ---- verif/pm_model.sv ----
// behavioural program memory read port
`timescale 1ns/10ps
module pm_model (
   // clock and pacing
   input wire logic clk,
   input wire logic slow,
   // read port
   input wire logic req,
   input wire logic [22:0] addr,
   output logic valid,
   output logic [23:0] rdata
);
   logic [1:0] cnt_q = 2'h0;
   logic [22:0] addr_q = 23'h000000;
   logic [23:0] last_q = 24'h000000;
   always @(posedge clk)
      if (req)
         cnt_q <= slow ? 2'h3 : 2'h1;
      else if (cnt_q != 2'h0)
         cnt_q <= cnt_q - 2'h1;
   always @(posedge clk)
      if (req)
         addr_q <= addr;
   always @(posedge clk)
      last_q <= rdata;
   assign valid = (cnt_q == 2'h1);
   // upper byte all ones so stray execution is harmless
   // the idle bus shows the inverse of its value in the previous cycle, so it alternates between the last word and its inverse
   assign rdata = valid ? {8'hFF, addr_q[22:7] ^ addr_q[15:0]} : ~last_q;
endmodule : pm_model

// ---- verif/program_space_window_chk.sv ----
// concurrent checks on the program space window ports
`timescale 1ns/10ps
`include "window_regs.svh"
module program_space_window_chk (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // core side
   input wire logic REQ_VALID,
   input wire window_pkg::access_req_t REQ_INFO,
   input wire logic TABLE_BUSY,
   input wire logic STALL,
   input wire logic RD_VALID,
   input wire logic [15:0] CTRL_RDATA,
   input wire logic [7:0] PAGE_RDATA,
   // memories
   input wire logic DM_REQ,
   input wire logic [15:0] DM_ADDR,
   input wire logic PM_REQ,
   input wire logic [22:0] PM_ADDR,
   input wire logic PM_VALID
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   logic take, hit, go, two, stall_q;
   // the finish cycle already has STALL low but still refuses a new request
   always_ff @(posedge CLK)
      stall_q <= STALL;
   assign take = REQ_VALID && !STALL && !stall_q;
   assign hit = take && REQ_INFO.effective_address[15] && CTRL_RDATA[`WIN_ENABLE_BIT];
   assign go = hit && !TABLE_BUSY;
   assign two = REQ_INFO.repeat_first || REQ_INFO.repeat_last || REQ_INFO.irq_exit
      || REQ_INFO.irq_resume;
   property p_miss;
      take && !hit |=> DM_REQ && !PM_REQ && DM_ADDR == $past(REQ_INFO.effective_address);
   endproperty
   a_miss: assert property (p_miss) else $error("miss not sent to data memory");
   property p_hit;
      go |=> PM_REQ && !DM_REQ
         && PM_ADDR == {$past(PAGE_RDATA), $past(REQ_INFO.effective_address[14:0])};
   endproperty
   a_hit: assert property (p_hit) else $error("window fetch address wrong");
   property p_table;
      PM_REQ |-> !$past(TABLE_BUSY);
   endproperty
   a_table: assert property (p_table) else $error("fetch during table access");
   property p_done;
      $fell(STALL) |=> RD_VALID;
   endproperty
   a_done: assert property (p_done) else $error("no read data after stall");
   property p_move;
      go && !REQ_INFO.in_repeat && REQ_INFO.instr_class != window_pkg::INSTR_OTHER
         |=> STALL ##1 (!PM_VALID || !STALL);
   endproperty
   a_move: assert property (p_move) else $error("move cost not one cycle");
   property p_other;
      go && !REQ_INFO.in_repeat && REQ_INFO.instr_class == window_pkg::INSTR_OTHER
         |=> STALL[*2];
   endproperty
   a_other: assert property (p_other) else $error("other cost under two cycles");
   property p_rpt_slow;
      go && REQ_INFO.in_repeat && two |=> STALL[*2];
   endproperty
   a_rpt_slow: assert property (p_rpt_slow) else $error("loop edge under two");
   property p_rpt_fast;
      go && REQ_INFO.in_repeat && !two |=> STALL ##1 (!PM_VALID || !STALL);
   endproperty
   a_rpt_fast: assert property (p_rpt_fast) else $error("loop body delayed");
endmodule : program_space_window_chk
bind program_space_window program_space_window_chk u_chk (
   .CLK(CLK),
   .RST_B(RST_B),
   .REQ_VALID(REQ_VALID),
   .REQ_INFO(REQ_INFO),
   .TABLE_BUSY(TABLE_BUSY),
   .STALL(STALL),
   .RD_VALID(RD_VALID),
   .CTRL_RDATA(CTRL_RDATA),
   .PAGE_RDATA(PAGE_RDATA),
   .DM_REQ(DM_REQ),
   .DM_ADDR(DM_ADDR),
   .PM_REQ(PM_REQ),
   .PM_ADDR(PM_ADDR),
   .PM_VALID(PM_VALID)
);

// ---- verif/program_space_window_tb_top.sv ----
// self-checking bench for the program space window
`timescale 1ns/10ps
module program_space_window_tb_top;
   logic CLK = 1'b0, RST_B = 1'b0, CTRL_WR = 1'b0, PAGE_WR = 1'b0, REQ_VALID = 1'b0;
   logic TABLE_BUSY = 1'b0, slow = 1'b0, STALL, RD_VALID, DM_REQ, PM_REQ, PM_VALID;
   logic [15:0] CTRL_WDATA = 16'h0000, CTRL_RDATA, RD_DATA, DM_ADDR;
   logic [7:0] PAGE_WDATA = 8'h00, PAGE_RDATA, pg = 8'h00;
   logic [22:0] PM_ADDR;
   logic [23:0] PM_RDATA;
   logic [16:0] e, s;
   logic en = 1'b0;
   window_pkg::access_req_t REQ_INFO = '0;
   logic [16:0] q[$];
   int fails = 0, compares = 0;
   program_space_window u_dut (
      .CLK(CLK),
      .RST_B(RST_B),
      .CTRL_WR(CTRL_WR),
      .CTRL_WDATA(CTRL_WDATA),
      .PAGE_WR(PAGE_WR),
      .PAGE_WDATA(PAGE_WDATA),
      .CTRL_RDATA(CTRL_RDATA),
      .PAGE_RDATA(PAGE_RDATA),
      .REQ_VALID(REQ_VALID),
      .REQ_INFO(REQ_INFO),
      .TABLE_BUSY(TABLE_BUSY),
      .STALL(STALL),
      .RD_VALID(RD_VALID),
      .RD_DATA(RD_DATA),
      .DM_REQ(DM_REQ),
      .DM_ADDR(DM_ADDR),
      .PM_REQ(PM_REQ),
      .PM_ADDR(PM_ADDR),
      .PM_VALID(PM_VALID),
      .PM_RDATA(PM_RDATA)
   );
   pm_model u_pm (.clk(CLK), .slow(slow), .req(PM_REQ), .addr(PM_ADDR), .valid(PM_VALID),
      .rdata(PM_RDATA));
   always #50 CLK = ~CLK;
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fails++;
         $display("FAIL %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   task automatic wreg(input logic [15:0] c, input logic [7:0] p);
      @(posedge CLK);
      {CTRL_WR, PAGE_WR, CTRL_WDATA, PAGE_WDATA} <= {2'b11, c, p};
      {pg, en} = {p, c[2]};
      @(posedge CLK);
      {CTRL_WR, PAGE_WR} <= 2'b00;
      @(posedge CLK);
      check("ctrl readback", 32'(CTRL_RDATA), 32'(c));
      check("page readback", 32'(PAGE_RDATA), 32'(p));
   endtask : wreg
   // exp of 0 means a plain data memory access, no wait
   task automatic acc(input logic [15:0] ea, input window_pkg::instr_class_t c,
      input logic [4:0] f, input int exp);
      logic [22:0] a;
      int n;
      a = {pg, ea[14:0]};
      @(posedge CLK);
      REQ_INFO <= {ea, c, f};
      REQ_VALID <= 1'b1;
      q.push_back((ea[15] && en) ? {1'b1, a[22:7] ^ a[15:0]} : {1'b0, ea});
      @(posedge CLK);
      REQ_VALID <= 1'b0;
      n = 1;
      while (exp > 0 && RD_VALID !== 1'b1 && n < 40)
      begin
         @(posedge CLK);
         n++;
      end
      if (exp > 0)
         check("cycles", 32'(n), 32'(exp));
   endtask : acc
   always @(posedge CLK)
      if (RD_VALID === 1'b1 || DM_REQ === 1'b1)
      begin
         e = q.pop_front();
         s = {RD_VALID, RD_VALID ? RD_DATA : DM_ADDR};
         check("read", s, e);
      end
   task tally_and_finish;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      void'($urandom(24));
      repeat (10) @(posedge CLK);
      RST_B <= 1'b1;
      repeat (3) @(posedge CLK);
      check("page reset", 32'(PAGE_RDATA), 32'h0);
      check("ctrl reset", 32'(CTRL_RDATA), 32'h0);
      wreg(16'h0000, 8'($urandom));
      acc(16'($urandom) | 16'h8000, window_pkg::INSTR_MOVE, 5'h00, 0);
      $display("test window_off done");
      for (int i = 0; i < 8; i++)
      begin
         wreg(16'h0004, i == 0 ? 8'h00 : i == 1 ? 8'hFF : 8'($urandom));
         acc(16'($urandom) & 16'h7FFF, window_pkg::INSTR_OTHER, 5'h1F, 0);
         acc(16'($urandom) | 16'h8000, (i == 2 || i > 3) ? window_pkg::INSTR_OTHER :
            i == 1 ? window_pkg::INSTR_DOUBLE_MOVE : window_pkg::INSTR_MOVE,
            i < 3 ? 5'h00 : i == 3 ? 5'h10 : 5'h10 | (5'h08 >> (i - 4)),
            (i == 2 || i > 3) ? 5 : 4);
      end
      $display("test classes done");
      slow <= 1'b1;
      acc(16'hFFFF, window_pkg::INSTR_OTHER, 5'h00, 6);
      slow <= 1'b0;
      $display("test slow_memory done");
      TABLE_BUSY <= 1'b1;
      fork
         begin
            repeat (6) @(posedge CLK);
            TABLE_BUSY <= 1'b0;
         end
      join_none
      acc(16'h8002, window_pkg::INSTR_MOVE, 5'h00, 9);
      $display("test table_busy done");
      @(posedge CLK);
      check("results left", 32'(q.size()), 32'h0);
      tally_and_finish;
   end
   initial
   begin
      #2000000;
      fails++;
      tally_and_finish;
   end
endmodule : program_space_window_tb_top
